// ==== tb_top.sv ====
`default_nettype none

module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ubrg_pkg::*;
  logic clk, nrst, wr, rd, tick, pen, syncm, hs, wide;
  logic [REG_ADDR_W-1:0] addr;
  logic [REG_DATA_W-1:0] wdata, rdata;
  logic [31:0] period;
  int miscompares = 0;
  int compares = 0;

  ubrg_top ubrg_top_i (.i_sys_clk(clk), .i_nrst(nrst), .i_addr(addr), .i_wdata(wdata), .i_wr(wr), .i_rd(rd),
    .o_rdata(rdata), .o_rate_tick(tick), .o_prescale_en(pen), .o_sync_mode(syncm), .o_high_speed(hs),
    .o_wide_divisor(wide));
  ubrg_peer ubrg_peer_i (.i_sys_clk(clk), .i_nrst(nrst), .i_rate_tick(tick), .o_period(period));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("BAD at %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask : check

  task automatic give_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, miscompares);
    if (miscompares == 0 && compares > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask : give_verdict

  task automatic wr_reg(input logic [REG_ADDR_W-1:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg

  task automatic rd_reg(input logic [REG_ADDR_W-1:0] a, output logic [7:0] v);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    v = rdata;
  endtask : rd_reg

  // Bounded wait; returns the number of edges until the tick is seen.
  task automatic wait_tick(output int k);
    k = 0;
    do begin
      @(posedge clk);
      #1;
      k++;
    end while (tick !== 1'b1 && k < 5000);
    check(tick, 1'b1);
  endtask : wait_tick

  task automatic rate(input logic s, input logic w, input logic h, input logic [7:0] lo, input logic [7:0] hi);
    int k;
    int p;
    logic [7:0] v;
    logic [7:0] c;
    logic [15:0] n;
    p = s ? 4 : (w && h) ? 4 : (w || h) ? 16 : 64;
    n = w ? {hi, lo} : {8'h00, lo};
    wr_reg(OFF_TX_CTRL, {3'h0, s, 1'b0, h, 2'h0});
    wr_reg(OFF_BAUD_CTRL, {4'h0, w, 3'h0});
    wr_reg(OFF_DIV_HIGH, hi);
    wr_reg(OFF_DIV_LOW, lo);
    check({syncm, wide, hs}, {s, w, h});
    repeat (3) wait_tick(k);
    @(posedge clk);
    #1;
    check(period, p * ((w ? {hi, lo} : {8'h00, lo}) + 1));
    rd_reg(OFF_RATE_STATUS, v);
    check(v[1:0], p == 64 ? 0 : p == 16 ? 1 : 2);
    rd_reg(OFF_DIV_LOW, v);
    check(v, lo);
    rd_reg(OFF_DIV_HIGH, v);
    check(v, hi);
    // A low count read freezes the high byte, so the pair is one count value no larger than n.
    rd_reg(OFF_COUNT_LOW, v);
    rd_reg(OFF_COUNT_HIGH, c);
    check({c, v} <= n, 1'b1);
  endtask : rate

  task automatic restart();
    int k;
    logic [7:0] v;
    rate(1'b1, 1'b0, 1'b0, 8'h01, 8'h07);
    wr_reg(OFF_DIV_LOW, 8'h01);
    wait_tick(k);
    // First tick lands P*(n+1) edges after the write, plus one for the restart and one for the tick register.
    check(k, 2 * PRESCALE_DIV4 + 2);
    rd_reg(OFF_RATE_STATUS, v);
    check(v[BIT_STAT_TICK_SEEN], 1'b1);
    rd_reg(OFF_RATE_STATUS, v);
    check(v[BIT_STAT_TICK_SEEN], 1'b0);
    repeat (3) @(posedge clk);
    wr_reg(OFF_DIV_HIGH, 8'h07);
    wait_tick(k);
    check(k, 2 * PRESCALE_DIV4 + 2);
  endtask : restart

  task automatic reset_and_fields();
    logic [7:0] v;
    for (int a = 0; a < 8; a++) begin
      rd_reg(a[REG_ADDR_W-1:0], v);
      check(v, 8'h00);
    end
    wr_reg(OFF_TX_CTRL, 8'hFF);
    rd_reg(OFF_TX_CTRL, v);
    check(v, 8'h14);
    wr_reg(OFF_BAUD_CTRL, 8'hFF);
    rd_reg(OFF_BAUD_CTRL, v);
    check(v, 8'h08);
  endtask : reset_and_fields

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial begin
    #600us;
    miscompares++;
    give_verdict();
  end

  initial begin
    nrst = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = '0;
    wdata = 8'h00;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    reset_and_fields();
    rate(1'b0, 1'b0, 1'b0, 8'h02, 8'h01);
    rate(1'b0, 1'b1, 1'b0, 8'h02, 8'h01);
    rate(1'b0, 1'b0, 1'b1, 8'h03, 8'h01);
    rate(1'b0, 1'b1, 1'b1, 8'h03, 8'h00);
    rate(1'b1, 1'b0, 1'b0, 8'h05, 8'h01);
    rate(1'b1, 1'b0, 1'b1, 8'h05, 8'h01);
    rate(1'b1, 1'b1, 1'b1, 8'h01, 8'h01);
    restart();
    give_verdict();
  end
endmodule : tb_top

`default_nettype wire

// ==== ubrg_chk.sv ====
`default_nettype none

module ubrg_chk
  import ubrg_pkg::*;
#(
  parameter int unsigned DIV_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [ubrg_pkg::REG_ADDR_W-1:0] i_addr,
  input wire logic [ubrg_pkg::REG_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [ubrg_pkg::REG_DATA_W-1:0] o_rdata,
  input wire logic o_rate_tick,
  input wire logic o_prescale_en,
  input wire logic o_sync_mode,
  input wire logic o_high_speed,
  input wire logic o_wide_divisor
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (!i_nrst);

  property p_rd_idle; !$past(i_rd) |-> o_rdata == 8'h00; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data not zero outside answer");
  property p_tick_pulse; o_rate_tick |=> !o_rate_tick; endproperty
  a_tick_pulse: assert property (p_tick_pulse) else $error("rate tick longer than one cycle");
  property p_tick_en; o_rate_tick |-> $past(o_prescale_en); endproperty
  a_tick_en: assert property (p_tick_en) else $error("rate tick without prescaled count");
  property p_sync; i_wr && i_addr == OFF_TX_CTRL |=> o_sync_mode == $past(i_wdata[4]); endproperty
  a_sync: assert property (p_sync) else $error("mode select not taken from bit 4");
  property p_hs; i_wr && i_addr == OFF_TX_CTRL |=> o_high_speed == $past(i_wdata[2]); endproperty
  a_hs: assert property (p_hs) else $error("high speed select not taken from bit 2");
  property p_wide; i_wr && i_addr == OFF_BAUD_CTRL |=> o_wide_divisor == $past(i_wdata[3]); endproperty
  a_wide: assert property (p_wide) else $error("wide select not taken from bit 3");
  property p_rst_lo; i_wr && i_addr == OFF_DIV_LOW |=> ##1 (!o_prescale_en && !o_rate_tick) [*3]; endproperty
  a_rst_lo: assert property (p_rst_lo) else $error("low byte write did not restart");
  property p_rst_hi; i_wr && i_addr == OFF_DIV_HIGH |=> ##1 (!o_prescale_en && !o_rate_tick) [*3]; endproperty
  a_rst_hi: assert property (p_rst_hi) else $error("high byte write did not restart");

  c_tick_sync: cover property (o_rate_tick && o_sync_mode);
  c_tick_wide: cover property (o_rate_tick && o_wide_divisor && !o_sync_mode);
  c_rd_high: cover property (i_rd && i_addr == OFF_DIV_HIGH);
endmodule : ubrg_chk

bind ubrg_top ubrg_chk #(.DIV_W(DIV_W)) ubrg_chk_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_addr(i_addr),
  .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_rate_tick(o_rate_tick),
  .o_prescale_en(o_prescale_en), .o_sync_mode(o_sync_mode), .o_high_speed(o_high_speed),
  .o_wide_divisor(o_wide_divisor));

`default_nettype wire

// ==== ubrg_peer.sv ====
`default_nettype none

module ubrg_peer (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_rate_tick,
  output logic [31:0] o_period
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [31:0] cnt_q;
  // The far port only sees the tick, so it judges the rate by the spacing of ticks.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      cnt_q <= 32'h0;
      o_period <= 32'h0;
    end else if (i_rate_tick) begin
      o_period <= cnt_q;
      cnt_q <= 32'h1;
    end else begin
      cnt_q <= cnt_q + 32'h1;
    end
  end
endmodule : ubrg_peer

`default_nettype wire

// ==== ubrg_pkg.sv ====
`default_nettype none

package ubrg_pkg;

  // Register bus geometry.
  localparam int unsigned REG_ADDR_W = 3;
  localparam int unsigned REG_DATA_W = 8;

  // Register indices on the plain register port.
  localparam logic [REG_ADDR_W-1:0] OFF_DIV_LOW = 3'h0;
  localparam logic [REG_ADDR_W-1:0] OFF_DIV_HIGH = 3'h1;
  localparam logic [REG_ADDR_W-1:0] OFF_TX_CTRL = 3'h2;
  localparam logic [REG_ADDR_W-1:0] OFF_BAUD_CTRL = 3'h3;
  localparam logic [REG_ADDR_W-1:0] OFF_COUNT_LOW = 3'h4;
  localparam logic [REG_ADDR_W-1:0] OFF_COUNT_HIGH = 3'h5;
  localparam logic [REG_ADDR_W-1:0] OFF_RATE_STATUS = 3'h6;

  // Field positions.
  localparam int unsigned BIT_SYNC_MODE = 4;
  localparam int unsigned BIT_HIGH_SPEED = 2;
  localparam int unsigned BIT_WIDE_DIVISOR = 3;
  localparam int unsigned BIT_STAT_MODE_LSB = 0;
  localparam int unsigned BIT_STAT_TICK_SEEN = 7;

  // Values after reset.
  localparam logic [7:0] RST_DIV_LOW = 8'h00;
  localparam logic [7:0] RST_DIV_HIGH = 8'h00;
  localparam logic RST_SYNC_MODE = 1'b0;
  localparam logic RST_HIGH_SPEED = 1'b0;
  localparam logic RST_WIDE_DIVISOR = 1'b0;

  // Clock rate of the generator.
  localparam int unsigned SYS_CLK_HZ = 100_000_000;

  // System clocks per divisor count in each divide mode.
  localparam int unsigned PRESCALE_W = 7;
  localparam logic [PRESCALE_W-1:0] PRESCALE_DIV64 = 7'h40;
  localparam logic [PRESCALE_W-1:0] PRESCALE_DIV16 = 7'h10;
  localparam logic [PRESCALE_W-1:0] PRESCALE_DIV4 = 7'h04;

  typedef enum logic [1:0] {
    UBRG_DIV64 = 2'b00,
    UBRG_DIV16 = 2'b01,
    UBRG_DIV4 = 2'b10
  } ubrg_div_t;

  // Divide mode from the three control bits.
  function automatic ubrg_div_t ubrg_div_sel(input logic sync_mode, input logic wide, input logic high_speed);
    ubrg_div_t sel;
    sel = UBRG_DIV64;
    if (sync_mode) begin
      sel = UBRG_DIV4;
    end else if (wide && high_speed) begin
      sel = UBRG_DIV4;
    end else if (wide || high_speed) begin
      sel = UBRG_DIV16;
    end
    return sel;
  endfunction : ubrg_div_sel

  function automatic logic [PRESCALE_W-1:0] ubrg_div_factor(input ubrg_div_t sel);
    logic [PRESCALE_W-1:0] f;
    case (sel)
      UBRG_DIV64: f = PRESCALE_DIV64;
      UBRG_DIV16: f = PRESCALE_DIV16;
      UBRG_DIV4: f = PRESCALE_DIV4;
      default: f = PRESCALE_DIV64;
    endcase
    return f;
  endfunction : ubrg_div_factor

endpackage : ubrg_pkg

`default_nettype wire

// ==== ubrg_prescaler.sv ====
`default_nettype none

module ubrg_prescaler #(
  parameter int unsigned WIDTH = 7
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_restart,
  input wire logic [WIDTH-1:0] i_factor,
  output logic o_en
);
  import ubrg_pkg::*;

  logic [WIDTH-1:0] count_q;
  logic wrap;

  // A factor lowered mid-count must not run the counter all the way round.
  assign wrap = (count_q >= (i_factor - {{(WIDTH-1){1'b0}}, 1'b1}));

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= '0;
    end else if (i_restart) begin
      count_q <= '0;
    end else if (wrap) begin
      count_q <= '0;
    end else begin
      count_q <= count_q + {{(WIDTH-1){1'b0}}, 1'b1};
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_en <= 1'b0;
    end else begin
      o_en <= wrap && !i_restart;
    end
  end

endmodule : ubrg_prescaler

`default_nettype wire

// ==== ubrg_reload_counter.sv ====
`default_nettype none

module ubrg_reload_counter #(
  parameter int unsigned WIDTH = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic i_restart,
  input wire logic i_en,
  input wire logic [WIDTH-1:0] i_load,
  output logic [WIDTH-1:0] o_count,
  output logic o_tick
);
  import ubrg_pkg::*;

  logic [WIDTH-1:0] count_q;

  assign o_count = count_q;

  // R16 load count reload
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_q <= '0;
    end else if (i_restart) begin
      count_q <= i_load;
    end else if (i_en) begin
      if (count_q == '0) begin
        count_q <= i_load;
      end else begin
        count_q <= count_q - {{(WIDTH-1){1'b0}}, 1'b1};
      end
    end
  end

  // R16 tick on zero
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      o_tick <= 1'b0;
    end else begin
      o_tick <= i_en && !i_restart && (count_q == '0);
    end
  end

endmodule : ubrg_reload_counter

`default_nettype wire

// ==== ubrg_top.sv ====
`default_nettype none

// Summary of operation
// R1 - Writing the low divisor byte restarts the bit rate counter from a fresh count.
// R2 - Writing the high divisor byte also restarts the bit rate counter.
// R3 - High divisor byte is ignored unless the wide divisor select bit is set.
// R4 - Low divisor register holds divisor bits 7 to 0, read and write.
// R5 - High divisor register holds divisor bits 15 to 8, read and write.
// R6 - Divisor n is the high and low bytes concatenated as one pair.
// R7 - Async, 8-bit, low speed: rate is clock over 64 times (n+1).
// R8 - Async, 16-bit, low speed: rate is clock over 16 times (n+1).
// R9 - Synchronous mode: rate is clock over 4 times (n+1), speed bit ignored.
// R10 - Transmit control register: mode select at bit 4, high speed at bit 2.
// R11 - Baud control register: wide divisor select at bit 3.
// R12 - Mode select one means synchronous, zero means asynchronous.
// R13 - Wide divisor select one uses 16-bit generator, zero uses 8-bit.
// R14 - Async high speed select one is high speed; ignored in synchronous mode.
// R15 - Async high speed: 16 times (n+1) for 8-bit, 4 times for 16-bit.
// R16 - Counter loads n, counts down per prescaled clock, ticks and reloads past zero.
module ubrg_top #(
  parameter int unsigned DIV_W = 16
) (
  input wire logic i_sys_clk,
  input wire logic i_nrst,
  input wire logic [ubrg_pkg::REG_ADDR_W-1:0] i_addr,
  input wire logic [ubrg_pkg::REG_DATA_W-1:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  output logic [ubrg_pkg::REG_DATA_W-1:0] o_rdata,
  output logic o_rate_tick,
  output logic o_prescale_en,
  output logic o_sync_mode,
  output logic o_high_speed,
  output logic o_wide_divisor
);
  import ubrg_pkg::*;

  logic [7:0] baud_divisor_low_q;
  logic [7:0] baud_divisor_high_q;
  logic sync_mode_q;
  logic high_speed_q;
  logic wide_divisor_q;
  logic restart_q;
  logic tick_seen_q;
  logic [7:0] count_high_snap_q;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;

  logic wr_div_low;
  logic wr_div_high;
  logic wr_tx_ctrl;
  logic wr_baud_ctrl;
  logic rd_count_low;
  logic rd_status;

  logic [DIV_W-1:0] baud_divisor;
  logic [DIV_W-1:0] divisor_eff;
  ubrg_div_t div_sel;
  logic [PRESCALE_W-1:0] prescale_factor;
  logic prescale_en;
  logic rate_tick;
  logic [DIV_W-1:0] bit_rate_count;

  // Register port decode.
  assign wr_div_low = i_wr && (i_addr == OFF_DIV_LOW);
  assign wr_div_high = i_wr && (i_addr == OFF_DIV_HIGH);
  assign wr_tx_ctrl = i_wr && (i_addr == OFF_TX_CTRL);
  assign wr_baud_ctrl = i_wr && (i_addr == OFF_BAUD_CTRL);
  assign rd_count_low = i_rd && (i_addr == OFF_COUNT_LOW);
  assign rd_status = i_rd && (i_addr == OFF_RATE_STATUS);

  // R4 low divisor storage
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      baud_divisor_low_q <= RST_DIV_LOW;
    end else if (wr_div_low) begin
      baud_divisor_low_q <= i_wdata;
    end
  end

  // R5 high divisor storage
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      baud_divisor_high_q <= RST_DIV_HIGH;
    end else if (wr_div_high) begin
      baud_divisor_high_q <= i_wdata;
    end
  end

  // Only the generator's own control bits are held; the rest of each control byte reads as zero.
  // R10 mode and speed bits
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync_mode_q <= RST_SYNC_MODE;
      high_speed_q <= RST_HIGH_SPEED;
    end else if (wr_tx_ctrl) begin
      sync_mode_q <= i_wdata[BIT_SYNC_MODE];
      high_speed_q <= i_wdata[BIT_HIGH_SPEED];
    end
  end

  // R11 wide divisor bit
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wide_divisor_q <= RST_WIDE_DIVISOR;
    end else if (wr_baud_ctrl) begin
      wide_divisor_q <= i_wdata[BIT_WIDE_DIVISOR];
    end
  end

  // The restart is delayed one cycle so that the counter reloads the byte just written,
  // not the value it replaces.
  // R1 low write restart
  // R2 high write restart
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= wr_div_low || wr_div_high;
    end
  end

  // R6 divisor pair
  assign baud_divisor = {baud_divisor_high_q, baud_divisor_low_q};

  // R3 high byte gated
  // R13 width select
  assign divisor_eff = wide_divisor_q ? baud_divisor : {8'h00, baud_divisor[7:0]};

  // R7 slow 8-bit
  // R8 slow 16-bit
  // R9 synchronous divide
  // R12 mode polarity
  // R14 speed polarity
  // R15 fast async
  assign div_sel = ubrg_div_sel(sync_mode_q, wide_divisor_q, high_speed_q);
  assign prescale_factor = ubrg_div_factor(div_sel);

  // A change of mode bits alone does not restart the count; the new factor applies to the prescaler
  // count already running, and the new divisor from the next counter reload.
  ubrg_prescaler #(
    .WIDTH(PRESCALE_W)
  ) u_prescaler (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_restart(restart_q),
    .i_factor(prescale_factor),
    .o_en(prescale_en)
  );

  // R16 bit rate counter
  ubrg_reload_counter #(
    .WIDTH(DIV_W)
  ) u_bit_rate_counter (
    .i_sys_clk(i_sys_clk),
    .i_nrst(i_nrst),
    .i_restart(restart_q),
    .i_en(prescale_en),
    .i_load(divisor_eff),
    .o_count(bit_rate_count),
    .o_tick(rate_tick)
  );

  // Sticky flag of a tick since the last status read; a tick in the reading cycle wins.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      tick_seen_q <= 1'b0;
    end else if (rate_tick) begin
      tick_seen_q <= 1'b1;
    end else if (rd_status) begin
      tick_seen_q <= 1'b0;
    end
  end

  // Reading the low count byte freezes the high byte, so a pair of reads is coherent.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      count_high_snap_q <= 8'h00;
    end else if (rd_count_low) begin
      count_high_snap_q <= bit_rate_count[15:8];
    end
  end

  // Read mux; unmapped indices read as zero.
  always_comb begin
    rdata_d = 8'h00;
    case (i_addr)
      OFF_DIV_LOW: rdata_d = baud_divisor_low_q;
      OFF_DIV_HIGH: rdata_d = baud_divisor_high_q;
      OFF_TX_CTRL: begin
        rdata_d[BIT_SYNC_MODE] = sync_mode_q;
        rdata_d[BIT_HIGH_SPEED] = high_speed_q;
      end
      OFF_BAUD_CTRL: rdata_d[BIT_WIDE_DIVISOR] = wide_divisor_q;
      OFF_COUNT_LOW: rdata_d = bit_rate_count[7:0];
      OFF_COUNT_HIGH: rdata_d = count_high_snap_q;
      OFF_RATE_STATUS: begin
        rdata_d[BIT_STAT_MODE_LSB +: 2] = div_sel;
        rdata_d[BIT_STAT_TICK_SEEN] = tick_seen_q;
      end
      default: rdata_d = 8'h00;
    endcase
  end

  // Read data stand for exactly the cycle after the strobe and are zero otherwise.
  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      rdata_q <= 8'h00;
    end else if (i_rd) begin
      rdata_q <= rdata_d;
    end else begin
      rdata_q <= 8'h00;
    end
  end

  assign o_rdata = rdata_q;
  assign o_rate_tick = rate_tick;
  assign o_prescale_en = prescale_en;
  assign o_sync_mode = sync_mode_q;
  assign o_high_speed = high_speed_q;
  assign o_wide_divisor = wide_divisor_q;

endmodule : ubrg_top

`default_nettype wire
